// >>> dv/ssr_tb.sv
// Self-checking bench of the stop-mode and reset-status unit
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int LONG_N = 64;
    localparam int SHORT_N = 4;
    logic clk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h0;
    logic stopExec = 1'b0, waitExec = 1'b0, moduleIrq = 1'b0, breakIrq = 1'b0;
    logic breakActive = 1'b0, shortRecoverySelect = 1'b0, resetPin = 1'b0;
    logic watchdogExpired = 1'b0, badOpcode = 1'b0, badAddress = 1'b0;
    logic opcodeFetch = 1'b0, usbResetReq = 1'b0;
    logic hreadyout, hresp, oscillatorOutputClockEn, crystalClockEn, stackStart;
    logic statusClearEnable;
    wire logic hready;
    int miscompares = 0;
    int n_checks = 0;
    assign hready = hreadyout;
    always #2 clk = ~clk;

    ssr_stop_reset #(.RECOVERY_LONG(LONG_N), .RECOVERY_SHORT(SHORT_N)) DUT (.clk(clk),
        .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .stopExec(stopExec), .waitExec(waitExec),
        .moduleIrq(moduleIrq), .breakIrq(breakIrq), .breakActive(breakActive),
        .shortRecoverySelect(shortRecoverySelect), .resetPin(resetPin),
        .watchdogExpired(watchdogExpired), .badOpcode(badOpcode), .badAddress(badAddress),
        .opcodeFetch(opcodeFetch), .usbResetReq(usbResetReq),
        .oscillatorOutputClockEn(oscillatorOutputClockEn), .crystalClockEn(crystalClockEn),
        .stackStart(stackStart), .statusClearEnable(statusClearEnable));

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic xfer(input logic wr, input logic [17:0] a, input logic [31:0] wd,
                        output logic [31:0] rd);
        int k;
        k = 0;
        hsel <= 1'b1;
        haddr <= {14'h0, a};
        htrans <= ssr_pkg::HTRANS_NONSEQ;
        hwrite <= wr;
        hsize <= ssr_pkg::HSIZE_WORD;
        do begin @(posedge clk); k++; end while (hready !== 1'b1 && k < 50);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        do begin @(posedge clk); k++; end while (hready !== 1'b1 && k < 50);
        rd = hrdata;
        if (k >= 50) begin
            miscompares++;
            $display("unexpected hready: expected 1 seen timeout");
        end
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask

    task automatic rd(input logic [17:0] a, input logic [31:0] exp, input string what);
        logic [31:0] v;
        xfer(1'b0, a, 32'h0, v);
        chk(what, exp, v);
    endtask

    task automatic wr(input logic [17:0] a, input logic [31:0] d);
        logic [31:0] v;
        xfer(1'b1, a, d, v);
    endtask

    // Fires one reset source; 5 is a data-access bad address
    task automatic fire(input int s);
        opcodeFetch <= (s == 2);
        watchdogExpired <= (s == 0);
        badOpcode <= (s == 1);
        badAddress <= (s == 2 || s == 5);
        usbResetReq <= (s == 3);
        resetPin <= (s == 4);
        @(posedge clk);
        {watchdogExpired, badOpcode, badAddress, usbResetReq, resetPin} <= 5'h00;
        opcodeFetch <= 1'b0;
        repeat (6) @(posedge clk);
    endtask

    task automatic t_map();
        rd(ssr_pkg::RESET_SOURCE_ADDR, 32'h80, "por_source");
        rd(ssr_pkg::RESET_SOURCE_ADDR, 32'h00, "source_cleared");
        rd(ssr_pkg::BREAK_STATUS_ADDR, 32'h00, "break_status");
        rd(ssr_pkg::BREAK_FLAG_CONTROL_ADDR, 32'h00, "flag_control");
        wr(18'h3F808, 32'hFF);
        rd(18'h3F808, 32'h00, "unmapped");
        $display("test map done");
    endtask

    task automatic t_sources();
        logic [7:0] e [6] = '{8'h20, 8'h10, 8'h08, 8'h04, 8'h40, 8'h00};
        for (int s = 0; s < 6; s++) begin
            fire(s);
            rd(ssr_pkg::RESET_SOURCE_ADDR, {24'h0, e[s]}, "source");
        end
        $display("test sources done");
    endtask

    task automatic t_stop(input logic sel, input int n);
        int cnt;
        cnt = 0;
        shortRecoverySelect <= sel;
        stopExec <= 1'b1;
        @(posedge clk);
        stopExec <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk("clocks_off", 32'h0, {30'h0, oscillatorOutputClockEn, crystalClockEn});
        moduleIrq <= 1'b1;
        do begin @(posedge clk); #1; cnt++; end while (stackStart !== 1'b1 && cnt < 9000);
        chk("recovery_len", n + 1, cnt);
        chk("clocks_on", 32'h3, {30'h0, oscillatorOutputClockEn, crystalClockEn});
        moduleIrq <= 1'b0;
        @(posedge clk);
        #1;
        chk("stack_pulse", 32'h0, {31'h0, stackStart});
        $display("test stop done");
    endtask

    task automatic t_break(input logic viaWait);
        int cnt;
        cnt = 0;
        stopExec <= !viaWait;
        waitExec <= viaWait;
        @(posedge clk);
        {stopExec, waitExec} <= 2'h0;
        breakIrq <= 1'b1;
        do begin @(posedge clk); #1; cnt++; end while (stackStart !== 1'b1 && cnt < 9000);
        breakIrq <= 1'b0;
        @(posedge clk);
        rd(ssr_pkg::BREAK_STATUS_ADDR, 32'h02, "break_exit");
        if (viaWait) fire(0);
        else wr(ssr_pkg::BREAK_STATUS_ADDR, 32'h0);
        rd(ssr_pkg::BREAK_STATUS_ADDR, 32'h00, "break_exit_clr");
        $display("test break done");
    endtask

    task automatic t_break_clear_enable();
        breakActive <= 1'b1;
        wr(ssr_pkg::BREAK_FLAG_CONTROL_ADDR, 32'h80);
        rd(ssr_pkg::BREAK_FLAG_CONTROL_ADDR, 32'h80, "break_clear_enable");
        chk("clear_en", 32'h1, {31'h0, statusClearEnable});
        wr(ssr_pkg::BREAK_FLAG_CONTROL_ADDR, 32'h00);
        @(posedge clk);
        #1;
        chk("clear_en", 32'h0, {31'h0, statusClearEnable});
        breakActive <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk("clear_en", 32'h1, {31'h0, statusClearEnable});
        $display("test break_clear_enable done");
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_map();
        t_sources();
        t_stop(1'b0, LONG_N);
        t_stop(1'b1, SHORT_N);
        t_break(1'b0);
        t_break(1'b1);
        t_break_clear_enable();
        conclude();
    end

    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        conclude();
    end
endmodule
`default_nettype wire

// >>> rtl/ssr_pkg.sv
// Shared constants and types of the stop-mode and reset-status unit
package ssr_pkg;
    // Printed register offsets are word indexes; byte address is four times the index
    localparam logic [15:0] BREAK_STATUS_IDX = 16'hFE00;
    localparam logic [15:0] RESET_SOURCE_IDX = 16'hFE01;
    localparam logic [15:0] BREAK_FLAG_CONTROL_IDX = 16'hFE03;
    localparam int ADDR_W = 18;
    localparam logic [17:0] BREAK_STATUS_ADDR = {BREAK_STATUS_IDX, 2'h0};
    localparam logic [17:0] RESET_SOURCE_ADDR = {RESET_SOURCE_IDX, 2'h0};
    localparam logic [17:0] BREAK_FLAG_CONTROL_ADDR = {BREAK_FLAG_CONTROL_IDX, 2'h0};
    // Field positions
    localparam int BREAK_EXIT_FLAG_BIT = 1;
    localparam int BREAK_CLEAR_ENABLE_BIT = 7;
    localparam int POWER_ON_BIT = 7;
    localparam int PIN_BIT = 6;
    localparam int WATCHDOG_BIT = 5;
    localparam int BAD_OPCODE_BIT = 4;
    localparam int BAD_ADDRESS_BIT = 3;
    localparam int USB_BIT = 2;
    // Reset values
    localparam logic [7:0] RESET_SOURCE_POR_VALUE = 8'h80;
    localparam logic [7:0] BREAK_STATUS_RESET = 8'h00;
    localparam logic [7:0] BREAK_FLAG_CONTROL_RESET = 8'h00;
    // Stop recovery lengths in crystal clock cycles
    localparam int RECOVERY_LONG_CYCLES = 4096;
    localparam int RECOVERY_SHORT_CYCLES = 32;
    localparam int COUNT_W = 13;
    // AHB encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    typedef enum logic [3:0] {
        ST_RUN = 4'h1,
        ST_WAIT = 4'h2,
        ST_STOP = 4'h4,
        ST_RECOVER = 4'h8
    } ssr_mode_t;
endpackage

// >>> rtl/ssr_stop_reset.sv
// Stop-mode sequencer, break exit flag and reset source register on AHB-Lite
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Stop entry clears counter, stops system clocks
// - Interrupt, reset or break leaves stop
// - Stacking waits until recovery delay elapses
// - Stop gates oscillator and crystal clocks
// - Recovery 4096 cycles, or 32 if short
// - Break leaving stop sets break exit flag
// - Break leaving wait sets break exit flag
// - Counter held in stop, then times recovery
// - Writing 0 or any reset clears flag
// - Six source flags bits 7..2, low bits zero
// - Reading reset source clears all its flags
// - Power-on sets bit 7, clears others
// - External pin reset sets pin flag
// - Watchdog expiry sets watchdog flag
// - Illegal opcode sets bad opcode flag
// - Bad address flag only on opcode fetch
// - USB reset request sets serial-bus flag
// - Break clear enable drives statusClearEnable in break; own flags clear ungated
// - Registers at FE00, FE01 and FE03
module ssr_stop_reset #(
    parameter int RECOVERY_LONG = ssr_pkg::RECOVERY_LONG_CYCLES,
    parameter int RECOVERY_SHORT = ssr_pkg::RECOVERY_SHORT_CYCLES
) (
    // Clock and power-on reset
    input wire logic clk,
    input wire logic rstn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Processor and module events
    input wire logic stopExec,
    input wire logic waitExec,
    input wire logic moduleIrq,
    input wire logic breakIrq,
    input wire logic breakActive,
    input wire logic shortRecoverySelect,
    // Reset sources
    input wire logic resetPin,
    input wire logic watchdogExpired,
    input wire logic badOpcode,
    input wire logic badAddress,
    input wire logic opcodeFetch,
    input wire logic usbResetReq,
    // Clock gates and status
    output logic oscillatorOutputClockEn,
    output logic crystalClockEn,
    output logic stackStart,
    output logic statusClearEnable
);
    typedef struct packed {
        ssr_pkg::ssr_mode_t mode;
        logic [ssr_pkg::COUNT_W-1:0] cnt;
        logic shortSel;
        logic [7:0] rstSrc;
        logic exitFlag;
        logic break_clear_enable;
        logic wrPend;
        logic [ssr_pkg::ADDR_W-1:0] wrAddr;
        logic [31:0] rdata;
        logic ready;
        logic clkEn;
        logic stackGo;
        logic clearOk;
        logic pinSync1;
        logic pinSync2;
        logic pinPrev;
    } ssr_state_t;

    localparam ssr_state_t RESET_STATE = '{
        mode: ssr_pkg::ST_RUN,
        cnt: '0,
        shortSel: 1'b0,
        rstSrc: ssr_pkg::RESET_SOURCE_POR_VALUE,
        exitFlag: 1'b0,
        break_clear_enable: 1'b0,
        wrPend: 1'b0,
        wrAddr: '0,
        rdata: 32'h0000_0000,
        ready: 1'b0,
        clkEn: 1'b1,
        stackGo: 1'b0,
        clearOk: 1'b1,
        pinSync1: 1'b0,
        pinSync2: 1'b0,
        pinPrev: 1'b0
    };
    localparam logic [ssr_pkg::COUNT_W-1:0] LAST_LONG = ssr_pkg::COUNT_W'(RECOVERY_LONG - 1);
    localparam logic [ssr_pkg::COUNT_W-1:0] LAST_SHORT = ssr_pkg::COUNT_W'(RECOVERY_SHORT - 1);

    ssr_state_t s;
    ssr_state_t next_s;
    logic addrPhase;
    logic pinEvent;
    logic [7:0] srcEvents;
    logic anyReset;
    logic [ssr_pkg::COUNT_W-1:0] lastCount;
    logic [ssr_pkg::ADDR_W-1:0] addrLow;
    logic [7:0] breakStatusView;
    logic [7:0] controlView;

    assign addrPhase = hsel && hready && htrans == ssr_pkg::HTRANS_NONSEQ;
    assign addrLow = haddr[ssr_pkg::ADDR_W-1:0];
    assign pinEvent = s.pinSync2 && !s.pinPrev;
    assign lastCount = s.shortSel ? LAST_SHORT : LAST_LONG;
    assign breakStatusView = 8'(s.exitFlag) << ssr_pkg::BREAK_EXIT_FLAG_BIT;
    assign controlView = 8'(s.break_clear_enable) << ssr_pkg::BREAK_CLEAR_ENABLE_BIT;

    always_comb begin
        srcEvents = 8'h00;
        srcEvents[ssr_pkg::PIN_BIT] = pinEvent;
        srcEvents[ssr_pkg::WATCHDOG_BIT] = watchdogExpired;
        srcEvents[ssr_pkg::BAD_OPCODE_BIT] = badOpcode;
        srcEvents[ssr_pkg::BAD_ADDRESS_BIT] = badAddress && opcodeFetch;
        srcEvents[ssr_pkg::USB_BIT] = usbResetReq;
        anyReset = |srcEvents;
    end

    always_comb begin
        next_s = s;
        next_s.pinSync1 = resetPin;
        next_s.pinSync2 = s.pinSync1;
        next_s.pinPrev = s.pinSync2;
        next_s.stackGo = 1'b0;
        next_s.ready = 1'b1;
        // Mode sequencing
        unique case (s.mode)
            ssr_pkg::ST_RUN: begin
                if (stopExec) begin
                    next_s.mode = ssr_pkg::ST_STOP;
                    next_s.cnt = '0;
                    next_s.shortSel = shortRecoverySelect;
                end else if (waitExec) begin
                    next_s.mode = ssr_pkg::ST_WAIT;
                end
            end
            ssr_pkg::ST_WAIT: begin
                if (moduleIrq || breakIrq) begin
                    next_s.mode = ssr_pkg::ST_RUN;
                    next_s.stackGo = 1'b1;
                end
            end
            ssr_pkg::ST_STOP: begin
                next_s.cnt = '0;
                if (moduleIrq || breakIrq) begin
                    next_s.mode = ssr_pkg::ST_RECOVER;
                end
            end
            ssr_pkg::ST_RECOVER: begin
                if (s.cnt == lastCount) begin
                    next_s.mode = ssr_pkg::ST_RUN;
                    next_s.stackGo = 1'b1;
                end else begin
                    next_s.cnt = s.cnt + 1'b1;
                end
            end
        endcase
        // Break leaving stop or wait
        if (breakIrq && (s.mode == ssr_pkg::ST_STOP || s.mode == ssr_pkg::ST_WAIT)) begin
            next_s.exitFlag = 1'b1;
        end
        // Bus write data phase; a hardware set beats a clear
        if (s.wrPend) begin
            unique case (s.wrAddr)
                ssr_pkg::BREAK_STATUS_ADDR: begin
                    if (!hwdata[ssr_pkg::BREAK_EXIT_FLAG_BIT] && !next_s.exitFlag) begin
                        next_s.exitFlag = 1'b0;
                    end else if (!hwdata[ssr_pkg::BREAK_EXIT_FLAG_BIT]) begin
                        next_s.exitFlag = (s.mode == ssr_pkg::ST_STOP
                            || s.mode == ssr_pkg::ST_WAIT) && breakIrq;
                    end
                end
                ssr_pkg::BREAK_FLAG_CONTROL_ADDR: begin
                    next_s.break_clear_enable = hwdata[ssr_pkg::BREAK_CLEAR_ENABLE_BIT];
                end
                default: begin
                end
            endcase
        end
        // Bus address phase
        next_s.wrPend = addrPhase && hwrite;
        next_s.wrAddr = addrLow;
        if (addrPhase && !hwrite) begin
            unique case (addrLow)
                ssr_pkg::BREAK_STATUS_ADDR: next_s.rdata = {24'h000000, breakStatusView};
                ssr_pkg::RESET_SOURCE_ADDR: begin
                    next_s.rdata = {24'h000000, s.rstSrc[7:2], 2'h0};
                    next_s.rstSrc = 8'h00;
                end
                ssr_pkg::BREAK_FLAG_CONTROL_ADDR: next_s.rdata = {24'h000000, controlView};
                default: next_s.rdata = 32'h0000_0000;
            endcase
        end
        // A reset source restarts the system and overrides the mode, counter, flags and stacking
        if (anyReset) begin
            next_s.rstSrc = srcEvents;
            next_s.mode = ssr_pkg::ST_RUN;
            next_s.cnt = '0;
            next_s.exitFlag = 1'b0;
            next_s.break_clear_enable = 1'b0;
            next_s.stackGo = 1'b0;
        end
        next_s.clkEn = next_s.mode == ssr_pkg::ST_RUN
            || next_s.mode == ssr_pkg::ST_WAIT;
        next_s.clearOk = next_s.break_clear_enable || !breakActive;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s <= RESET_STATE;
        end else begin
            s <= next_s;
        end
    end

    assign hreadyout = s.ready;
    assign hresp = 1'b0;
    assign hrdata = s.rdata;
    assign oscillatorOutputClockEn = s.clkEn;
    assign crystalClockEn = s.clkEn;
    assign stackStart = s.stackGo;
    assign statusClearEnable = s.clearOk;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    AST_STOP_CLOCKS_OFF: assert property (
        s.mode == ssr_pkg::ST_STOP |-> !crystalClockEn && !oscillatorOutputClockEn)
        else $error("clocks running in stop");
    AST_STOP_COUNTER_HELD: assert property (
        s.mode == ssr_pkg::ST_RUN && stopExec && !anyReset |=> s.cnt == '0 [*2])
        else $error("recovery counter not held");
    AST_SHORT_RECOVERY: assert property (
        s.mode == ssr_pkg::ST_RECOVER && s.shortSel && s.cnt == LAST_SHORT && !anyReset
        |=> stackStart && s.mode == ssr_pkg::ST_RUN)
        else $error("short recovery end wrong");
    AST_NO_EARLY_STACK: assert property (
        stackStart && $past(s.mode) == ssr_pkg::ST_RECOVER |-> $past(s.cnt) == $past(lastCount))
        else $error("stacking before recovery done");
    AST_BREAK_FLAG: assert property (
        breakIrq && s.mode == ssr_pkg::ST_STOP && !anyReset
        |=> s.exitFlag && s.mode == ssr_pkg::ST_RECOVER)
        else $error("break exit flag not set");
    AST_SOURCE_READ: assert property (
        addrPhase && !hwrite && addrLow == ssr_pkg::RESET_SOURCE_ADDR && !anyReset
        |=> s.rstSrc == 8'h00 && hrdata[7:0] == {$past(s.rstSrc[7:2]), 2'h0})
        else $error("reset source read wrong");
    AST_WATCHDOG_FLAG: assert property (
        watchdogExpired |=> s.rstSrc[ssr_pkg::WATCHDOG_BIT] && s.mode == ssr_pkg::ST_RUN)
        else $error("watchdog flag missing");
    AST_BADADDR_FETCH: assert property (
        $rose(s.rstSrc[ssr_pkg::BAD_ADDRESS_BIT]) |-> $past(badAddress && opcodeFetch))
        else $error("bad address flag from data access");
    AST_CLEAR_GATE: assert property (
        !statusClearEnable |-> $past(breakActive) && !s.break_clear_enable)
        else $error("status clear gate wrong");

    COV_STOP_IRQ: cover property (s.mode == ssr_pkg::ST_STOP ##1 s.mode == ssr_pkg::ST_RECOVER);
    COV_WAIT_BREAK: cover property (s.mode == ssr_pkg::ST_WAIT && breakIrq);
    COV_SRC_READ: cover property (addrPhase && addrLow == ssr_pkg::RESET_SOURCE_ADDR);
endmodule
`default_nettype wire
